// ===== can_irq_vector.sv
`timescale 1ns/100ps
`include "can_irq_map.svh"

module can_irq_vector
   import can_irq_pkg::*;
#(
   parameter int NUM_OBJ   = 32,
   parameter int MODE_W    = 3
) (
   // clock and reset
   input  wire logic              SYS_CLK_IN,
   input  wire logic              NRST_IN,
   // register port
   input  wire reg_req_t          REG_REQ_IN,
   input  wire logic              REG_STROBE_IN,
   output logic [31:0]            REG_RDATA_OUT,
   // event sources
   input  wire event_in_t         EVENT_IN,
   input  wire logic [MODE_W-1:0] OPMODE_IN,
   // per-FIFO flag images
   input  wire fifo_flags_t       FIFO_FLAGS_IN,
   // receive filter hit
   input  wire logic              RX_ACCEPT_IN,
   input  wire logic [4:0]        RX_FILTER_IN,
   // transmit requests
   input  wire logic [31:0]       TX_SENT_IN,
   output logic [31:0]            SEND_REQUEST_OUT,
   // interrupt summary
   output logic                   IRQ_PENDING_OUT,
   output logic                   RX_IRQ_OUT,
   output logic                   TX_IRQ_OUT
);

   logic [1:0]        rst_sync_q;
   logic              rst_n;

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // register decode
   wire        wr_en      = REG_STROBE_IN && REG_REQ_IN.write;
   wire        wr_int     = wr_en && (REG_REQ_IN.index == `REG_INT_IDX);
   wire        wr_send_request_bits   = wr_en && (REG_REQ_IN.index == `REG_SEND_REQUEST_BITS_IDX);
   wire [31:0] byte_mask  = {{8{REG_REQ_IN.byte_en[3]}}, {8{REG_REQ_IN.byte_en[2]}},
                             {8{REG_REQ_IN.byte_en[1]}}, {8{REG_REQ_IN.byte_en[0]}}};
   wire [31:0] wr_ones    = REG_REQ_IN.wdata & byte_mask;
   wire [31:0] wr_zeros   = ~REG_REQ_IN.wdata & byte_mask;

   // enables
   logic [15:0] enable_q;
   logic [15:0] enable_d;
   wire  [15:0] en_wmask = byte_mask[31:16] & `INT_EN_MASK;

   assign enable_d = wr_int ? ((enable_q & ~en_wmask) | (REG_REQ_IN.wdata[31:16] & en_wmask))
                            : enable_q;

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         enable_q <= 16'h0000;
      end else begin
         enable_q <= enable_d;
      end
   end

   wire ivm_en  = enable_q[`INT_IVM_EN  - `INT_EN_LSB];
   wire wak_en  = enable_q[`INT_WAK_EN  - `INT_EN_LSB];
   wire cerr_en = enable_q[`INT_CERR_EN - `INT_EN_LSB];
   wire serr_en = enable_q[`INT_SERR_EN - `INT_EN_LSB];
   wire rxov_en = enable_q[`INT_RXOV_EN - `INT_EN_LSB];
   wire txat_en = enable_q[`INT_TXAT_EN - `INT_EN_LSB];
   wire tef_en  = enable_q[`INT_TEF_EN  - `INT_EN_LSB];
   wire mod_en  = enable_q[`INT_MOD_EN  - `INT_EN_LSB];
   wire tbc_en  = enable_q[`INT_TBC_EN  - `INT_EN_LSB];
   wire rx_en   = enable_q[`INT_RX_EN   - `INT_EN_LSB];
   wire tx_en   = enable_q[`INT_TX_EN   - `INT_EN_LSB];

   // mode tracking
   logic [MODE_W-1:0] mode_q;
   logic              mode_valid_q;
   wire               mode_changed = mode_valid_q && (OPMODE_IN != mode_q);

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         mode_q       <= MODE_W'(`RST_MODE);
         mode_valid_q <= 1'b0;
      end else begin
         mode_q       <= OPMODE_IN;
         mode_valid_q <= 1'b1;
      end
   end

   // sticky flags: set wins over a software clear in the same cycle
   wire serr_set = EVENT_IN.address_error || EVENT_IN.mab_error;

   logic ivm_q;
   logic wak_q;
   logic cerr_q;
   logic serr_q;
   logic mod_q;
   logic tbc_q;
   logic addr_cause_q;
   logic mab_cause_q;

   wire clr_ivm  = wr_int && wr_zeros[`INT_IVM_FLAG];
   wire clr_wak  = wr_int && wr_zeros[`INT_WAK_FLAG];
   wire clr_cerr = wr_int && wr_zeros[`INT_CERR_FLAG];
   wire clr_serr = wr_int && wr_zeros[`INT_SERR_FLAG];
   wire clr_mod  = wr_int && wr_zeros[`INT_MOD_FLAG];
   wire clr_tbc  = wr_int && wr_zeros[`INT_TBC_FLAG];

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ivm_q        <= 1'b0;
         wak_q        <= 1'b0;
         cerr_q       <= 1'b0;
         serr_q       <= 1'b0;
         mod_q        <= 1'b0;
         tbc_q        <= 1'b0;
         addr_cause_q <= 1'b0;
         mab_cause_q  <= 1'b0;
      end else begin
         ivm_q        <= EVENT_IN.invalid_message  || (ivm_q  && !clr_ivm);
         wak_q        <= EVENT_IN.wakeup           || (wak_q  && !clr_wak);
         cerr_q       <= EVENT_IN.bus_error        || (cerr_q && !clr_cerr);
         serr_q       <= serr_set                  || (serr_q && !clr_serr);
         mod_q        <= mode_changed              || (mod_q  && !clr_mod);
         tbc_q        <= EVENT_IN.counter_overflow || (tbc_q  && !clr_tbc);
         addr_cause_q <= EVENT_IN.address_error || (addr_cause_q && !clr_serr);
         mab_cause_q  <= EVENT_IN.mab_error     || (mab_cause_q  && !clr_serr);
      end
   end

   // summary vectors, images of the FIFO side, with bit 0 of both receive vectors forced to zero
   wire [31:0] rx_pending_bits  = FIFO_FLAGS_IN.rx_pending  & 32'hffff_fffe;
   wire [31:0] rx_overflow_bits = FIFO_FLAGS_IN.rx_overflow & 32'hffff_fffe;
   wire [31:0] tx_pending_bits  = FIFO_FLAGS_IN.tx_pending;
   wire [31:0] tx_attempt_bits  = FIFO_FLAGS_IN.tx_attempt;

   wire rx_fifo_flag      = |rx_pending_bits;
   wire tx_fifo_flag      = |tx_pending_bits;
   wire rx_overflow_flag  = |rx_overflow_bits;
   wire tx_attempt_flag   = |tx_attempt_bits;
   wire tef_flag          = FIFO_FLAGS_IN.tef_pending;

   // enabled flag terms
   wire [31:0] rx_fifo_live = rx_en ? rx_pending_bits : 32'h0000_0000;
   wire [31:0] tx_fifo_live = tx_en ? tx_pending_bits : 32'h0000_0000;
   wire        ivm_live     = ivm_q && ivm_en;
   wire        wak_live     = wak_q && wak_en;
   wire        cerr_live    = cerr_q && cerr_en;
   wire        serr_live    = serr_q && serr_en;
   wire        mod_live     = mod_q && mod_en;
   wire        tbc_live     = tbc_q && tbc_en;
   wire        rxov_live    = rx_overflow_flag && rxov_en;
   wire        txat_live    = tx_attempt_flag && txat_en;
   wire        tef_live     = tef_flag && tef_en;
   wire        crc_live     = EVENT_IN.serial_checksum_error
                              && enable_q[`INT_CRC_EN - `INT_EN_LSB];
   wire        ecc_live     = EVENT_IN.memory_correction_error
                              && enable_q[`INT_ECC_EN - `INT_EN_LSB];

   // highest set bit of a 32-bit vector as a FIFO code, or none
   function automatic logic [6:0] top_fifo(input logic [31:0] v);
      logic [6:0] code;
      code = `CODE_NONE;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            code = 7'(i);
         end
      end
      return code;
   endfunction

   wire [6:0] rx_code_d   = top_fifo(rx_fifo_live);
   wire [6:0] tx_code_d   = top_fifo(tx_fifo_live);
   wire [6:0] fifo_code_d = top_fifo(rx_fifo_live | tx_fifo_live);

   logic [6:0] gen_code_d;

   always_comb begin
      if (txat_live) begin
         gen_code_d = `CODE_TX_ATTEMPT;
      end else if (tef_live) begin
         gen_code_d = `CODE_TEF;
      end else if (ivm_live) begin
         gen_code_d = `CODE_INVALID;
      end else if (mod_live) begin
         gen_code_d = `CODE_MODE_CHG;
      end else if (tbc_live) begin
         gen_code_d = `CODE_TBC_OVF;
      end else if (serr_live && mab_cause_q) begin
         gen_code_d = `CODE_MAB_ERR;
      end else if (serr_live) begin
         gen_code_d = `CODE_ADDR_ERR;
      end else if (rxov_live) begin
         gen_code_d = `CODE_RX_OVF;
      end else if (wak_live) begin
         gen_code_d = `CODE_WAKEUP;
      end else if (cerr_live) begin
         gen_code_d = `CODE_BUS_ERR;
      end else begin
         gen_code_d = fifo_code_d;
      end
   end

   // filter hit capture
   logic [4:0] filter_hit_q;

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         filter_hit_q <= `RST_HIT;
      end else if (RX_ACCEPT_IN) begin
         filter_hit_q <= RX_FILTER_IN;
      end
   end

   // transmit request bits, one per object
   logic [31:0] send_req_q;

   genvar g;
   generate
      for (g = 0; g < NUM_OBJ; g++) begin : g_req
         wire req_set = wr_send_request_bits && wr_ones[g];
         always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               send_req_q[g] <= 1'b0;
            end else if (req_set) begin
               send_req_q[g] <= 1'b1;
            end else if (TX_SENT_IN[g]) begin
               send_req_q[g] <= 1'b0;
            end
         end
      end
      for (g = NUM_OBJ; g < 32; g++) begin : g_req_unused
         assign send_req_q[g] = 1'b0;
      end
   endgenerate
   // writing zero leaves the bit alone, so software never withdraws a request; only TX_SENT_IN or reset clears it

   // code register and outputs
   logic [6:0] rx_code_q;
   logic [6:0] tx_code_q;
   logic [6:0] gen_code_q;
   logic       irq_q;
   logic       rx_irq_q;
   logic       tx_irq_q;

   wire irq_d = ivm_live || wak_live || cerr_live || serr_live || mod_live || tbc_live
             || rxov_live || txat_live || tef_live || crc_live || ecc_live
             || (|rx_fifo_live) || (|tx_fifo_live);

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rx_code_q  <= `CODE_NONE;
         tx_code_q  <= `CODE_NONE;
         gen_code_q <= `CODE_NONE;
         irq_q      <= 1'b0;
         rx_irq_q   <= 1'b0;
         tx_irq_q   <= 1'b0;
      end else begin
         rx_code_q  <= rx_code_d;
         tx_code_q  <= tx_code_d;
         gen_code_q <= gen_code_d;
         irq_q      <= irq_d;
         rx_irq_q   <= |rx_fifo_live;
         tx_irq_q   <= |tx_fifo_live;
      end
   end

   wire [31:0] vec_word = {1'b0, rx_code_q, 1'b0, tx_code_q, 3'b000, filter_hit_q,
                           1'b0, gen_code_q};

   wire [31:0] int_word = {enable_q & `INT_EN_MASK,
                           ivm_q, wak_q, cerr_q, serr_q,
                           rx_overflow_flag, tx_attempt_flag,
                           EVENT_IN.serial_checksum_error, EVENT_IN.memory_correction_error,
                           3'b000, tef_flag, mod_q, tbc_q, rx_fifo_flag, tx_fifo_flag};

   logic [31:0] rdata_d;

   always_comb begin
      unique case (REG_REQ_IN.index)
         `REG_VEC_IDX:    rdata_d = vec_word;
         `REG_INT_IDX:    rdata_d = int_word;
         `REG_RECEIVE_FIFO_FLAG_IDX:   rdata_d = rx_pending_bits;
         `REG_RECEIVE_OVERFLOW_FLAG_IDX: rdata_d = rx_overflow_bits;
         `REG_TRANSMIT_FIFO_FLAG_IDX:   rdata_d = tx_pending_bits;
         `REG_TRANSMIT_ATTEMPT_FLAG_IDX: rdata_d = tx_attempt_bits;
         `REG_SEND_REQUEST_BITS_IDX:  rdata_d = send_req_q;
         default:         rdata_d = `RST_WORD;
      endcase
   end

   logic [31:0] rdata_q;

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `RST_WORD;
      end else if (REG_STROBE_IN && !REG_REQ_IN.write) begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA_OUT    = rdata_q;
   assign SEND_REQUEST_OUT = send_req_q;
   assign IRQ_PENDING_OUT  = irq_q;
   assign RX_IRQ_OUT       = rx_irq_q;
   assign TX_IRQ_OUT       = tx_irq_q;

endmodule

// ===== can_irq_map.svh
`ifndef CAN_IRQ_MAP_SVH
`define CAN_IRQ_MAP_SVH

// register indices on the internal register port
`define REG_VEC_IDX        3'h0
`define REG_INT_IDX        3'h1
`define REG_RECEIVE_FIFO_FLAG_IDX       3'h2
`define REG_RECEIVE_OVERFLOW_FLAG_IDX     3'h3
`define REG_TRANSMIT_FIFO_FLAG_IDX       3'h4
`define REG_TRANSMIT_ATTEMPT_FLAG_IDX     3'h5
`define REG_SEND_REQUEST_BITS_IDX      3'h6

// interrupt code register field positions
`define VEC_RX_LSB         24
`define VEC_TX_LSB         16
`define VEC_HIT_LSB        8
`define VEC_GEN_LSB        0

// interrupt register: writable enable bits and flag positions
`define INT_EN_MASK        16'hff1f
`define INT_EN_LSB         16
`define INT_IVM_EN         31
`define INT_WAK_EN         30
`define INT_CERR_EN        29
`define INT_SERR_EN        28
`define INT_RXOV_EN        27
`define INT_TXAT_EN        26
`define INT_CRC_EN         25
`define INT_ECC_EN         24
`define INT_TEF_EN         20
`define INT_MOD_EN         19
`define INT_TBC_EN         18
`define INT_RX_EN          17
`define INT_TX_EN          16
`define INT_IVM_FLAG       15
`define INT_WAK_FLAG       14
`define INT_CERR_FLAG      13
`define INT_SERR_FLAG      12
`define INT_RXOV_FLAG      11
`define INT_TXAT_FLAG      10
`define INT_CRC_FLAG       9
`define INT_ECC_FLAG       8
`define INT_TEF_FLAG       4
`define INT_MOD_FLAG       3
`define INT_TBC_FLAG       2
`define INT_RX_FLAG        1
`define INT_TX_FLAG        0

// interrupt codes
`define CODE_QUEUE         7'h00
`define CODE_NONE          7'h40
`define CODE_BUS_ERR       7'h41
`define CODE_WAKEUP        7'h42
`define CODE_RX_OVF        7'h43
`define CODE_ADDR_ERR      7'h44
`define CODE_MAB_ERR       7'h45
`define CODE_TBC_OVF       7'h46
`define CODE_MODE_CHG      7'h47
`define CODE_INVALID       7'h48
`define CODE_TEF           7'h49
`define CODE_TX_ATTEMPT    7'h4a

`define RST_WORD           32'h0000_0000
`define RST_MODE           3'h0
`define RST_HIT            5'h00

`endif

// ===== can_irq_pkg.sv
package can_irq_pkg;

   typedef struct packed {
      logic [2:0]  index;
      logic        write;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic invalid_message;
      logic wakeup;
      logic bus_error;
      logic address_error;
      logic mab_error;
      logic counter_overflow;
      logic serial_checksum_error;
      logic memory_correction_error;
   } event_in_t;

   typedef struct packed {
      logic [31:0] rx_pending;
      logic [31:0] rx_overflow;
      logic [31:0] tx_pending;
      logic [31:0] tx_attempt;
      logic        tef_pending;
   } fifo_flags_t;

endpackage

// ===== can_irq_vector_checker.sv
`timescale 1ns/100ps
`include "can_irq_map.svh"
module can_irq_vector_checker
   import can_irq_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        NRST_IN,
   input  wire reg_req_t    REG_REQ_IN,
   input  wire logic        REG_STROBE_IN,
   input  wire logic [31:0] REG_RDATA_OUT,
   input  wire fifo_flags_t FIFO_FLAGS_IN,
   input  wire logic [31:0] TX_SENT_IN,
   input  wire logic [31:0] SEND_REQUEST_OUT,
   input  wire logic        RX_IRQ_OUT,
   input  wire logic        TX_IRQ_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   wire logic       rd_stb = REG_STROBE_IN && !REG_REQ_IN.write;
   wire logic       req_wr = REG_STROBE_IN && REG_REQ_IN.write
                             && REG_REQ_IN.index == `REG_SEND_REQUEST_BITS_IDX && REG_REQ_IN.byte_en == 4'hf;
   wire logic       req_any = REG_STROBE_IN && REG_REQ_IN.write
                              && REG_REQ_IN.index == `REG_SEND_REQUEST_BITS_IDX;
   wire logic [2:0] idx    = REG_REQ_IN.index;

   chk_send_request_bits_set: assert property (req_wr |=> (SEND_REQUEST_OUT & $past(REG_REQ_IN.wdata)) == $past(REG_REQ_IN.wdata)) else $error("request bit not set");
   chk_send_request_bits_done: assert property ((TX_SENT_IN != 32'h0 && !req_any) |=> (SEND_REQUEST_OUT & $past(TX_SENT_IN)) == 32'h0) else $error("request bit not cleared");
   chk_send_request_bits_hold: assert property (TX_SENT_IN == 32'h0 |=> (SEND_REQUEST_OUT & $past(SEND_REQUEST_OUT)) == $past(SEND_REQUEST_OUT)) else $error("request bit lost");
   chk_rdata_stands: assert property (!rd_stb |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
   chk_send_request_bits_read: assert property ((rd_stb && idx == `REG_SEND_REQUEST_BITS_IDX) |=> REG_RDATA_OUT == $past(SEND_REQUEST_OUT)) else $error("request read wrong");
   chk_rx_summary: assert property ((rd_stb && idx == `REG_RECEIVE_FIFO_FLAG_IDX) |=> REG_RDATA_OUT == ($past(FIFO_FLAGS_IN.rx_pending) & 32'hffff_fffe)) else $error("rx summary wrong");
   chk_tx_summary: assert property ((rd_stb && idx == `REG_TRANSMIT_FIFO_FLAG_IDX) |=> REG_RDATA_OUT == $past(FIFO_FLAGS_IN.tx_pending)) else $error("tx summary wrong");
   chk_attempt_image: assert property ((rd_stb && idx == `REG_TRANSMIT_ATTEMPT_FLAG_IDX) |=> REG_RDATA_OUT == $past(FIFO_FLAGS_IN.tx_attempt)) else $error("attempt image wrong");
   chk_rx_irq_idle: assert property ((FIFO_FLAGS_IN.rx_pending & 32'hffff_fffe) == 32'h0 |=> !RX_IRQ_OUT) else $error("rx irq without source");
   chk_tx_irq_idle: assert property (FIFO_FLAGS_IN.tx_pending == 32'h0 |=> !TX_IRQ_OUT) else $error("tx irq without source");

   cover property (req_wr);
   cover property (TX_SENT_IN != 32'h0 && SEND_REQUEST_OUT != 32'h0);
   cover property (rd_stb && idx == 3'h7);
endmodule

bind can_irq_vector can_irq_vector_checker u_chk (
   .SYS_CLK_IN       (SYS_CLK_IN),
   .NRST_IN          (NRST_IN),
   .REG_REQ_IN       (REG_REQ_IN),
   .REG_STROBE_IN    (REG_STROBE_IN),
   .REG_RDATA_OUT    (REG_RDATA_OUT),
   .FIFO_FLAGS_IN    (FIFO_FLAGS_IN),
   .TX_SENT_IN       (TX_SENT_IN),
   .SEND_REQUEST_OUT (SEND_REQUEST_OUT),
   .RX_IRQ_OUT       (RX_IRQ_OUT),
   .TX_IRQ_OUT       (TX_IRQ_OUT)
);

// ===== tb_can_irq_vector.sv
`timescale 1ns/100ps
`include "can_irq_map.svh"
module tb_can_irq_vector import can_irq_pkg::*;;
   localparam logic [31:0] EN_ALL = 32'hff1f_0000;
   localparam logic [6:0]  NO     = `CODE_NONE;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   reg_req_t    req = '0;
   logic        strobe = 1'b0;
   event_in_t   ev = '0;
   logic [2:0]  opmode = 3'h0;
   fifo_flags_t ff = '0;
   logic        accept = 1'b0;
   logic [4:0]  filt = 5'h00;
   logic [31:0] sent = 32'h0;
   logic [31:0] rdata;
   logic [31:0] sendreq;
   logic        irq;
   logic        rx_irq;
   logic        tx_irq;
   logic [31:0] rd;
   logic [4:0]  hit = 5'h00;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;

   can_irq_vector u_dut (
      .SYS_CLK_IN(clk), .NRST_IN(nrst), .REG_REQ_IN(req), .REG_STROBE_IN(strobe),
      .REG_RDATA_OUT(rdata), .EVENT_IN(ev), .OPMODE_IN(opmode), .FIFO_FLAGS_IN(ff),
      .RX_ACCEPT_IN(accept), .RX_FILTER_IN(filt), .TX_SENT_IN(sent),
      .SEND_REQUEST_OUT(sendreq), .IRQ_PENDING_OUT(irq), .RX_IRQ_OUT(rx_irq),
      .TX_IRQ_OUT(tx_irq));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_mismatch = n_mismatch + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic [2:0] idx, input logic wr, input logic [31:0] wd);
      @(negedge clk);
      req = '{index: idx, write: wr, byte_en: 4'hf, wdata: wd};
      strobe = 1'b1;
      @(negedge clk);
      strobe = 1'b0;
      rd = rdata;
   endtask

   task automatic vec_is(input logic [6:0] rx, input logic [6:0] tx, input logic [6:0] gen);
      bus(`REG_VEC_IDX, 1'b0, 32'h0);
      check(rd, {1'b0, rx, 1'b0, tx, 3'h0, hit, 1'b0, gen});
   endtask

   task automatic pulse(input event_in_t e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = '0;
   endtask

   task automatic test_events();
      int         sh[6] = '{7, 6, 5, 4, 3, 2};
      int         fl[6] = '{15, 14, 13, 12, 12, 2};
      logic [6:0] code[6] = '{`CODE_INVALID, `CODE_WAKEUP, `CODE_BUS_ERR,
                              `CODE_ADDR_ERR, `CODE_MAB_ERR, `CODE_TBC_OVF};
      vec_is(NO, NO, NO);
      check(sendreq, 32'h0);
      for (int i = 0; i < 6; i++) begin
         bus(`REG_INT_IDX, 1'b1, EN_ALL);
         pulse(event_in_t'(8'h01 << sh[i]));
         vec_is(NO, NO, code[i]);
         repeat (3) @(negedge clk);
         bus(`REG_INT_IDX, 1'b0, 32'h0);
         check(rd, EN_ALL | (32'h1 << fl[i]));
         check({31'h0, irq}, 32'h1);
      end
      bus(`REG_INT_IDX, 1'b1, EN_ALL);
      pulse(event_in_t'(8'h20));
      pulse(event_in_t'(8'h40));
      vec_is(NO, NO, `CODE_WAKEUP);
      bus(`REG_INT_IDX, 1'b1, 32'hdf1f_0000);
      pulse(event_in_t'(8'h20));
      vec_is(NO, NO, NO);
      check({31'h0, irq}, 32'h0);
      bus(`REG_INT_IDX, 1'b0, 32'h0);
      check(rd, 32'hdf1f_2000);
      bus(`REG_INT_IDX, 1'b1, EN_ALL);
      @(negedge clk);
      opmode = 3'h4;
      repeat (2) @(negedge clk);
      vec_is(NO, NO, `CODE_MODE_CHG);
      bus(`REG_INT_IDX, 1'b0, 32'h0);
      check(rd, EN_ALL | 32'h8);
   endtask

   task automatic fcase(input logic [31:0] rxp, txp, rxo, txa, input logic transmit_event_fifo,
                        input logic [6:0] rx, tx, gen);
      @(negedge clk);
      ff = '{rx_pending: rxp, rx_overflow: rxo, tx_pending: txp, tx_attempt: txa,
             tef_pending: transmit_event_fifo};
      vec_is(rx, tx, gen);
      check({30'h0, rx_irq, tx_irq}, {30'h0, rx != NO, tx != NO});
   endtask

   task automatic test_fifo();
      bus(`REG_INT_IDX, 1'b1, EN_ALL);
      fcase(32'h21, 0, 0, 0, 0, 7'h05, NO, 7'h05);
      fcase(32'h21, 32'h8000_0001, 0, 0, 0, 7'h05, 7'h1f, 7'h1f);
      fcase(32'h1, 32'h1, 0, 0, 0, NO, `CODE_QUEUE, `CODE_QUEUE);
      fcase(0, 0, 32'h4, 0, 0, NO, NO, `CODE_RX_OVF);
      fcase(0, 0, 0, 0, 1, NO, NO, `CODE_TEF);
      fcase(32'h2, 32'h2, 32'h4, 32'h8, 1, 7'h01, 7'h01, `CODE_TX_ATTEMPT);
      bus(`REG_INT_IDX, 1'b1, EN_ALL);
      bus(`REG_INT_IDX, 1'b0, 32'h0);
      check(rd, EN_ALL | 32'h0c13);
      ff = '{32'hffff_ffff, 32'h8000_0000, 32'hffff_ffff, 32'h1, 1'b0};
      bus(`REG_RECEIVE_FIFO_FLAG_IDX, 1'b0, 32'h0);
      check(rd, 32'hffff_fffe);
      bus(`REG_RECEIVE_OVERFLOW_FLAG_IDX, 1'b1, 32'h0);
      bus(`REG_RECEIVE_OVERFLOW_FLAG_IDX, 1'b0, 32'h0);
      check(rd, 32'h8000_0000);
      bus(`REG_TRANSMIT_ATTEMPT_FLAG_IDX, 1'b0, 32'h0);
      check(rd, 32'h1);
      bus(`REG_INT_IDX, 1'b1, 32'hff1d_0000);
      fcase(32'h20, 0, 0, 0, 0, NO, NO, NO);
      ff = '0;
   endtask

   task automatic test_misc();
      bus(`REG_SEND_REQUEST_BITS_IDX, 1'b1, 32'h8000_0001);
      check(sendreq, 32'h8000_0001);
      bus(`REG_SEND_REQUEST_BITS_IDX, 1'b1, 32'h0);
      bus(`REG_SEND_REQUEST_BITS_IDX, 1'b0, 32'h0);
      check(rd, 32'h8000_0001);
      sent = 32'h1;
      @(negedge clk);
      sent = 32'h0;
      check(sendreq, 32'h8000_0000);
      bus(3'h7, 1'b1, 32'hffff_ffff);
      bus(3'h7, 1'b0, 32'h0);
      check(rd, 32'h0);
      check(sendreq, 32'h8000_0000);
      ev = event_in_t'(8'h02);
      bus(`REG_INT_IDX, 1'b0, 32'h0);
      check(rd, 32'hff1d_0200);
      check({31'h0, irq}, 32'h1);
      ev = '0;
      accept = 1'b1;
      filt = 5'h1f;
      @(negedge clk);
      accept = 1'b0;
      filt = 5'h03;
      hit = 5'h1f;
      vec_is(NO, NO, NO);
   endtask

   initial begin
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      test_events();
      test_fifo();
      test_misc();
      print_verdict();
   end
endmodule
